// ==== hdl/rtcm_pkg.sv ====
package rtcm_pkg;
  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [5:0] IDX_CTRL    = 6'h00;
  localparam logic [5:0] IDX_MONTH   = 6'h08;
  localparam logic [5:0] IDX_YEAR    = 6'h09;
  localparam logic [5:0] IDX_MIN_ALM = 6'h0A;
  localparam logic [5:0] IDX_HR_ALM  = 6'h0B;
  localparam logic [5:0] IDX_STATUS  = 6'h10;
  localparam logic [5:0] IDX_MASK    = 6'h11;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ALM_DIS_BIT   = 7;
  localparam int PM_BIT        = 5;
  localparam int CTRL_H12_BIT  = 0;
  localparam int EV_ALARM_BIT  = 0;
  localparam int EV_YEAR_BIT   = 1;
  localparam logic [7:0] MONTH_MASK   = 8'h1F;
  localparam logic [7:0] HR_ALM_MASK  = 8'hBF;
  localparam logic [7:0] EV_MASK      = 8'h03;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] MONTH_RST    = 8'h01;
  localparam logic [7:0] YEAR_RST     = 8'h00;
  localparam logic [7:0] MIN_ALM_RST  = 8'h80;
  localparam logic [7:0] HR_ALM_RST   = 8'h80;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  // ****************************************
  // calendar limits (bcd)
  // ****************************************
  localparam logic [7:0] MONTH_FIRST  = 8'h01;
  localparam logic [7:0] MONTH_LAST   = 8'h12;
  localparam logic [7:0] MONTH_FEB    = 8'h02;
  localparam logic [7:0] YEAR_LAST    = 8'h99;
endpackage

// ==== hdl/rtcm_regs.sv ====
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
// What this block does
// [RULE1] month kept as bcd 1 to 12 in bits 4:0
// [RULE2] year kept as bcd 0 to 99 over all eight bits
// [RULE3] alarm registers occupy two consecutive slots 0Ah to 0Bh
// [RULE4] minute alarm bit 7 disables minute compare, reset value 1
// [RULE5] minute alarm target is bcd 0 to 59 in bits 6:0
// [RULE6] hour alarm bit 7 disables hour compare, reset 1, both formats
// [RULE7] 12-hour format: bcd hour 1 to 12 in 4:0, bit 5 afternoon
// [RULE8] 24-hour format: bcd hour 0 to 23 in 5:0, bit 6 unused
// [RULE9] hour format select bit in first control register picks layout
// [RULE10] year divisible by four, including zero, gives february 29 days
// [RULE11] alarm event when all enabled fields match current time
module rtcm_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        month_tick_i,
  input  wire logic [7:0]  cur_minute_i,
  input  wire logic [7:0]  cur_hour24_i,
  output logic      [7:0]  days_in_month_o,
  output logic             leap_year_o,
  output logic             irq_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]  month;
    logic [7:0]  year;
    logic [7:0]  min_alm;
    logic [7:0]  hr_alm;
    logic [7:0]  ctrl;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic [31:0] rdata;
    logic        ack;
    logic        match;
    logic [7:0]  dim;
    logic        leap;
  } rtcm_state_t;

  rtcm_state_t s_q;
  rtcm_state_t s_d;

  // ****************************************
  // bcd helpers
  // ****************************************
  function automatic logic [6:0] bcd2bin(input logic [7:0] v);
    // widen before the product so the tens digit is not cut to four bits
    bcd2bin = (7'(v[7:4]) * 7'h0A) + 7'(v[3:0]);
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [6:0] v);
    logic [3:0] tens;
    tens = 4'(v / 7'h0A);
    bin2bcd = {tens, 4'(v % 7'h0A)};
  endfunction

  // wraps to first once past last
  function automatic logic [7:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last) begin
      bcd_step = first;
    end else begin
      bcd_step = bin2bcd(bcd2bin(v) + 7'h01);
    end
  endfunction

  function automatic logic is_leap(input logic [7:0] yr);
    is_leap = (bcd2bin(yr) % 7'h04) == 7'h00; // RULE10
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] mo,
                                            input logic       leap);
    case (mo)
      8'h02:   month_days = leap ? 8'h29 : 8'h28; // RULE10
      8'h04,
      8'h06,
      8'h09,
      8'h11:   month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  // alarm hour in 24-hour bcd; 12 am is 00, 12 pm stays 12
  function automatic logic [7:0] alm_hour24(input logic [7:0] a,
                                            input logic       h12);
    logic [6:0] h;
    h = bcd2bin({3'h0, a[4:0]});
    if (!h12) begin
      alm_hour24 = {2'h0, a[5:0]}; // RULE8
    end else if (a[rtcm_pkg::PM_BIT]) begin
      alm_hour24 = bin2bcd((h == 7'h0C) ? h : 7'(h + 7'h0C)); // RULE7
    end else begin
      alm_hour24 = bin2bcd((h == 7'h0C) ? 7'h00 : h); // RULE7
    end
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic       req;
  logic       done;
  logic       wr;
  logic [5:0] idx;
  logic [7:0] wb;
  logic [7:0] rd;
  logic       min_en;
  logic       hr_en;
  logic       match_now;
  logic [7:0] ev;

  always_comb begin
    s_d  = s_q;
    req  = cyc_i && stb_i;
    // write and read clear land on the edge the master sees ack
    done = req && s_q.ack;
    wr   = done && we_i && sel_i[0];
    idx  = adr_i[7:2];
    wb   = dat_i[7:0];
    ev   = 8'h00;

    // calendar advance, fed by the day carry of the time counters
    if (month_tick_i) begin
      s_d.month = bcd_step(s_q.month, rtcm_pkg::MONTH_LAST,
                           rtcm_pkg::MONTH_FIRST); // RULE1
      if (s_q.month == rtcm_pkg::MONTH_LAST) begin
        s_d.year = bcd_step(s_q.year, rtcm_pkg::YEAR_LAST,
                            rtcm_pkg::YEAR_RST); // RULE2
        if (s_q.year == rtcm_pkg::YEAR_LAST) begin
          ev[rtcm_pkg::EV_YEAR_BIT] = 1'b1;
        end
      end
    end

    // alarm compare; all fields disabled never fires
    min_en    = !s_q.min_alm[rtcm_pkg::ALM_DIS_BIT]; // RULE4
    hr_en     = !s_q.hr_alm[rtcm_pkg::ALM_DIS_BIT]; // RULE6
    match_now = (min_en || hr_en)
             && (!min_en || ({1'b0, s_q.min_alm[6:0]} == cur_minute_i)) // RULE5
             && (!hr_en || (alm_hour24(s_q.hr_alm, s_q.ctrl[rtcm_pkg::CTRL_H12_BIT])
                            == cur_hour24_i)); // RULE9
    s_d.match = match_now;
    if (match_now && !s_q.match) begin
      ev[rtcm_pkg::EV_ALARM_BIT] = 1'b1; // RULE11
    end

    // register writes
    if (wr) begin
      case (idx)
        rtcm_pkg::IDX_CTRL:    s_d.ctrl    = wb;
        rtcm_pkg::IDX_MONTH:   s_d.month   = wb & rtcm_pkg::MONTH_MASK; // RULE1
        rtcm_pkg::IDX_YEAR:    s_d.year    = wb; // RULE2
        rtcm_pkg::IDX_MIN_ALM: s_d.min_alm = wb; // RULE3
        rtcm_pkg::IDX_HR_ALM:  s_d.hr_alm  = wb & rtcm_pkg::HR_ALM_MASK; // RULE3
        rtcm_pkg::IDX_MASK:    s_d.mask    = wb & rtcm_pkg::EV_MASK;
        default:               s_d.ctrl    = s_d.ctrl;
      endcase
    end

    // read data, unmapped slots read zero
    case (idx)
      rtcm_pkg::IDX_CTRL:    rd = s_q.ctrl;
      rtcm_pkg::IDX_MONTH:   rd = s_q.month;
      rtcm_pkg::IDX_YEAR:    rd = s_q.year;
      rtcm_pkg::IDX_MIN_ALM: rd = s_q.min_alm;
      rtcm_pkg::IDX_HR_ALM:  rd = s_q.hr_alm;
      rtcm_pkg::IDX_STATUS:  rd = s_q.status;
      rtcm_pkg::IDX_MASK:    rd = s_q.mask;
      default:               rd = 8'h00;
    endcase

    // sticky status; a new event wins over the read clear
    if (done && !we_i && idx == rtcm_pkg::IDX_STATUS) begin
      s_d.status = ev;
    end else begin
      s_d.status = s_q.status | ev;
    end

    s_d.ack   = req && !s_q.ack;
    s_d.rdata = (req && !s_q.ack) ? {24'h0, rd} : s_q.rdata;
    s_d.leap  = is_leap(s_d.year); // RULE10
    s_d.dim   = month_days(s_d.month, s_d.leap); // RULE10
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q         <= '0;
      s_q.month   <= rtcm_pkg::MONTH_RST;
      s_q.year    <= rtcm_pkg::YEAR_RST;
      s_q.min_alm <= rtcm_pkg::MIN_ALM_RST; // RULE4
      s_q.hr_alm  <= rtcm_pkg::HR_ALM_RST; // RULE6
      s_q.ctrl    <= rtcm_pkg::CTRL_RST;
      s_q.dim     <= 8'h31;
      s_q.leap    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o           = s_q.rdata;
  assign ack_o           = s_q.ack;
  assign days_in_month_o = s_q.dim;
  assign leap_year_o     = s_q.leap;
  // level: high while any unmasked sticky bit stands
  assign irq_o           = |(s_q.status & s_q.mask);

endmodule

// ==== sim/rtcm_host.sv ====
`timescale 1ns/1ps
module rtcm_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = {3'h0, 8'h00, 4'h1, 32'h0};
  end
  // held until ack is sampled; released lines show inverted junk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h3, w, a, 24'h0, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i[7:0];
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'h0, ~a, 24'hFFFFFF, ~d};
  endtask
endmodule

// ==== sim/rtcm_regs_checker.sv ====
`timescale 1ns/1ps
module rtcm_regs_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [7:0]  days_in_month_o,
  input wire logic        leap_year_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_mon; ack_o && !we_i && adr_i == 8'h20 |-> dat_o[7:5] == 3'h0; endproperty
  a_mon: assert property (p_mon) else $error("month high bits set");
  property p_hr; ack_o && !we_i && adr_i == 8'h2C |-> !dat_o[6]; endproperty
  a_hr: assert property (p_hr) else $error("hour alarm bit 6 set");
  property p_top; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_top: assert property (p_top) else $error("read data upper bits set");
  property p_dim; days_in_month_o inside {8'h28, 8'h29, 8'h30, 8'h31}; endproperty
  a_dim: assert property (p_dim) else $error("month length invalid");
  property p_lp; days_in_month_o == 8'h29 |-> leap_year_o; endproperty
  a_lp: assert property (p_lp) else $error("29 days outside leap year");
  property p_nl; days_in_month_o == 8'h28 |-> !leap_year_o; endproperty
  a_nl: assert property (p_nl) else $error("28 days in leap year");
endmodule
bind rtcm_regs rtcm_regs_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .dat_o, .ack_o, .days_in_month_o, .leap_year_o);

// ==== sim/rtcm_regs_tb.sv ====
`timescale 1ns/1ps
module rtcm_regs_tb;
  logic        clk_i, rst_i, month_tick_i, cyc, stb, we, ack, leap, irq;
  logic [7:0]  adr, cur_min, cur_hr, dim, q;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          mismatches, checks, ticks;
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  rtcm_host host (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  rtcm_regs DUT (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .month_tick_i,
    .cur_minute_i(cur_min), .cur_hour24_i(cur_hr), .days_in_month_o(dim),
    .leap_year_o(leap), .irq_o(irq));
  // ***
  // helpers
  // ***
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // outputs are registered, so let them settle first
  task automatic pins(input logic [7:0] d, input logic l, input logic i);
    repeat (3) @(posedge clk_i);
    chk("days", d, dim);
    chk("leap", {7'h0, l}, {7'h0, leap});
    chk("irq", {7'h0, i}, {7'h0, irq});
  endtask
  // ***
  // scenarios
  // ***
  task automatic t_reset();
    rc(8'h20, 8'h01);
    rc(8'h24, 8'h00);
    rc(8'h28, 8'h80);
    rc(8'h2C, 8'h80);
    rc(8'h3C, 8'h00);
    pins(8'h31, 1'b1, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_write();
    logic [7:0] tv [6][3] = '{'{8'h20, 8'h12, 8'h12}, '{8'h20, 8'hFF, 8'h1F},
      '{8'h24, 8'h99, 8'h99}, '{8'h28, 8'h59, 8'h59}, '{8'h2C, 8'h32, 8'h32},
      '{8'h2C, 8'hFF, 8'hBF}};
    for (int k = 0; k < 6; k++) begin
      wr(tv[k][0], tv[k][1]);
      rc(tv[k][0], tv[k][2]);
    end
    $display("write test done");
  endtask
  task automatic t_cal();
    wr(8'h24, 8'h99);
    wr(8'h20, 8'h12);
    @(posedge clk_i) month_tick_i <= 1'b1;
    @(posedge clk_i) month_tick_i <= 1'b0;
    rc(8'h20, 8'h01);
    rc(8'h24, 8'h00);
    pins(8'h31, 1'b1, 1'b0);
    rc(8'h40, 8'h02);
    rc(8'h40, 8'h00);
    wr(8'h20, 8'h02);
    pins(8'h29, 1'b1, 1'b0);
    wr(8'h24, 8'h01);
    pins(8'h28, 1'b0, 1'b0);
    wr(8'h24, 8'h04);
    wr(8'h20, 8'h04);
    pins(8'h30, 1'b1, 1'b0);
    $display("calendar test done");
  endtask
  task automatic t_alarm();
    wr(8'h44, 8'h01);
    wr(8'h2C, 8'h80);
    wr(8'h28, 8'h30);
    @(posedge clk_i) cur_min <= 8'h30;
    pins(8'h30, 1'b1, 1'b1);
    rc(8'h40, 8'h01);
    pins(8'h30, 1'b1, 1'b0);
    wr(8'h28, 8'h80);
    wr(8'h00, 8'h01);
    wr(8'h2C, 8'h21);
    pins(8'h30, 1'b1, 1'b0);
    @(posedge clk_i) cur_hr <= 8'h13;
    pins(8'h30, 1'b1, 1'b1);
    rc(8'h40, 8'h01);
    $display("alarm test done");
  endtask
  // ***
  // run control
  // ***
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    {rst_i, month_tick_i, cur_min, cur_hr} = {2'h2, 8'h00, 8'h00};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_write();
    t_cal();
    t_alarm();
    print_verdict();
  end
endmodule
